// ---- logic/scsi_glue_pkg.sv ----
// Shared constants for the SCSI glue bridge and its processor-side end
package scsi_glue_pkg;
  // ---------------------------------------------------------------
  // Address map (24-bit routed bus)
  // ---------------------------------------------------------------
  localparam int          ADDR_W          = 24;
  localparam logic [3:0]  REGS_A23_20     = 4'he;   // 0x1E00000 window, low 24 bits
  localparam logic [3:0]  DMA_A23_20      = 4'hf;   // 0x1F00000 window, low 24 bits
  localparam logic [23:0] SLOT_BASE       = 24'h200000;
  localparam logic [23:0] SLOT_LAST       = 24'h3fffff;
  localparam logic [23:0] DRAM_LAST       = 24'h3fffff;  // system DRAM within region
  localparam logic [23:0] EXP_CARD_BASE   = 24'h400000;  // card area in region
  localparam logic [23:0] EXP_CARD_LAST   = 24'hdfffff;
  localparam logic [31:0] REGION_BASE     = 32'h01000000;
  localparam logic [31:0] REGION_LAST     = 32'h01ffffff;
  localparam logic [31:0] PROG_MEM_LAST   = 32'h001fffff;  // program memory select
  localparam logic [31:0] SRAM_BASE       = 32'h00400000;  // static RAM select
  localparam logic [31:0] SRAM_LAST       = 32'h004fffff;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ          = 50;
  localparam int ACTIVITY_MS      = 50;
  localparam int ACTIVITY_CYCLES  = ACTIVITY_MS * 1000 * CLK_MHZ;
  localparam int ACK_DELAY_CYCLES = 2;   // strobe setup before acknowledge
  // ---------------------------------------------------------------
  // Static options
  // ---------------------------------------------------------------
  localparam logic DMA_CHAN_ONE   = 1'b0;
  localparam logic DMA_CHAN_TWO   = 1'b1;
  localparam logic [2:0] INT_LEVEL_TWO = 3'h2;
endpackage : scsi_glue_pkg

// ---- logic/cpu_bus_if.sv ----
// Processor bus between host end and SCSI glue end
`timescale 1ns/1ps
`default_nettype none
interface cpu_bus_if;
  logic [31:0] addr;
  logic        rw;          // 1 read
  logic        as;          // address strobe, active high here
  logic        ds;
  logic        expansion_region_select;
  logic        ack_o_val;   // transfer_size_ack value driven by glue
  logic        ack_oe;      // glue drives acknowledge
  logic        transfer_size_ack;
  logic [1:0]  dma_req;     // per channel request
  logic [1:0]  dma_ack;     // per channel acknowledge from processor
  logic        reset_n;
  // Resolved acknowledge: undriven reads inactive
  assign transfer_size_ack = ack_oe & ack_o_val;
  modport glue (input addr, rw, as, ds, expansion_region_select, dma_ack, reset_n,
                transfer_size_ack, output ack_o_val, ack_oe, dma_req);
  modport host (output addr, rw, as, ds, expansion_region_select, dma_ack, reset_n,
                input transfer_size_ack, dma_req);
endinterface : cpu_bus_if
`default_nettype wire

// ---- logic/scsi_glue.sv ----
// SCSI glue end: bus strobes, DMA strobes, acknowledge, decode, activity
// Behaviour
// - DMA window accesses become controller DMA cycles
// - Processor DMA runs dual-address cycle steal
// - Controller uses non-burst DMA, no byte control
// - Acknowledge SCSI accesses as 16-bit port
// - Qualify decode with shared expansion region select
// - Region select asserted over 01000000-01FFFFFF
// - Expansion decoders require region select asserted
// - Expansion decoders never overlap SCSI or DRAM
// - Spare slot decode needs region select negated
// - Region select runs native async, external ack
// - Retriggerable one-shot on REQ drives activity
// - Controller interrupt routed to level two
// - Static option picks DMA channel 1 or 2
// - Memory selects acknowledged inside the processor
// - Select and read for CPU; write both
// - Active-high controller reset from low board reset
`timescale 1ns/1ps
`default_nettype none
module scsi_glue
  import scsi_glue_pkg::*;
#(
  parameter int ACT_CYCLES = scsi_glue_pkg::ACTIVITY_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  cpu_bus_if.glue   bus,
  input  wire logic dma_channel_option_i,     // 0 channel 1, 1 channel 2
  input  wire logic controller_dma_request_i,
  input  wire logic controller_irq_i,
  input  wire logic scsi_req_i,
  output logic      ctrl_cs_o,
  output logic      ctrl_rd_o,
  output logic      ctrl_wr_o,
  output logic      ctrl_dack_o,
  output logic      controller_reset_out_o,
  output logic      scsi_activity_o,
  output logic [2:0] interrupt_level_o,
  output logic      dram_sel_o,
  output logic      exp_card_sel_o,
  output logic      slot_card_sel_o
);
  import scsi_glue_pkg::*;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  function automatic logic in_range(input logic [23:0] a, input logic [23:0] lo,
                                    input logic [23:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  logic [23:0] a24;
  logic        region;
  logic        regs_hit;
  logic        dma_hit;
  logic        scsi_hit;
  assign a24      = bus.addr[23:0];
  assign region   = bus.expansion_region_select & bus.as;
  assign regs_hit = region && (a24[23:20] == REGS_A23_20);
  assign dma_hit  = region && (a24[23:20] == DMA_A23_20);
  assign scsi_hit = regs_hit | dma_hit;

  // Board selects, fully decoded so none overlaps the SCSI windows
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dram_sel_o      <= 1'b0;
      exp_card_sel_o  <= 1'b0;
      slot_card_sel_o <= 1'b0;
    end else begin
      dram_sel_o      <= region && a24 <= DRAM_LAST;
      exp_card_sel_o  <= region && in_range(a24, EXP_CARD_BASE, EXP_CARD_LAST);
      slot_card_sel_o <= bus.as && !bus.expansion_region_select
                         && in_range(a24, SLOT_BASE, SLOT_LAST);
    end
  end

  // ---------------------------------------------------------------
  // Cycle sequencer
  // ---------------------------------------------------------------
  typedef enum {S_IDLE, S_STROBE, S_ACK} cyc_t;
  cyc_t       state_q;
  logic [1:0] dly_q;
  logic       is_dma_q;

  // Strobes run a fixed setup then acknowledge until address strobe falls
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q  <= S_IDLE;
      dly_q    <= 2'h0;
      is_dma_q <= 1'b0;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (scsi_hit && bus.ds) begin
            state_q  <= S_STROBE;
            is_dma_q <= dma_hit;
            dly_q    <= 2'h0;
          end
        end
        S_STROBE: begin
          if (!bus.as) begin
            state_q <= S_IDLE;
          end else if (dly_q == 2'(ACK_DELAY_CYCLES - 1)) begin
            state_q <= S_ACK;
          end else begin
            dly_q <= dly_q + 2'h1;
          end
        end
        S_ACK: begin
          if (!bus.as) begin
            state_q <= S_IDLE;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Controller strobes from flip-flops; select and read only on CPU cycles
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_cs_o   <= 1'b0;
      ctrl_rd_o   <= 1'b0;
      ctrl_wr_o   <= 1'b0;
      ctrl_dack_o <= 1'b0;
    end else begin
      ctrl_cs_o   <= (state_q != S_IDLE) && bus.as && !is_dma_q;
      ctrl_rd_o   <= (state_q != S_IDLE) && bus.as && !is_dma_q && bus.rw;
      ctrl_wr_o   <= (state_q != S_IDLE) && bus.as && !bus.rw;
      ctrl_dack_o <= (state_q != S_IDLE) && bus.as && is_dma_q;
    end
  end

  // Acknowledge: driven while region selected, asserted in ACK state
  assign bus.ack_o_val = (state_q == S_ACK) && bus.as;
  assign bus.ack_oe    = region;

  // ---------------------------------------------------------------
  // DMA request steering and static routing
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bus.dma_req <= 2'b00;
    end else begin
      bus.dma_req[0] <= controller_dma_request_i && (dma_channel_option_i == DMA_CHAN_ONE);
      bus.dma_req[1] <= controller_dma_request_i && (dma_channel_option_i == DMA_CHAN_TWO);
    end
  end

  // Interrupt level fixed; zero means no request pending
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      interrupt_level_o <= 3'h0;
    end else begin
      interrupt_level_o <= controller_irq_i ? INT_LEVEL_TWO : 3'h0;
    end
  end

  // Controller reset follows the board reset line, registered
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      controller_reset_out_o <= 1'b1;
    end else begin
      controller_reset_out_o <= !bus.reset_n;
    end
  end

  // ---------------------------------------------------------------
  // Activity one-shot: each REQ rising edge reloads the count
  // ---------------------------------------------------------------
  localparam int ACT_W = $clog2(ACT_CYCLES + 1);
  logic [ACT_W-1:0] act_q;
  logic             req_q;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      act_q <= '0;
      req_q <= 1'b0;
    end else begin
      req_q <= scsi_req_i;
      if (scsi_req_i && !req_q) begin
        act_q <= ACT_W'(ACT_CYCLES);
      end else if (act_q != '0) begin
        act_q <= act_q - ACT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      scsi_activity_o <= 1'b0;
    end else begin
      scsi_activity_o <= (scsi_req_i && !req_q) || (act_q > ACT_W'(1));
    end
  end
endmodule : scsi_glue
`default_nettype wire

// ---- logic/scsi_host_end.sv ----
// Processor-side end: runs bus cycles and DMA cycle-steal moves
`timescale 1ns/1ps
`default_nettype none
module scsi_host_end
  import scsi_glue_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  cpu_bus_if.host          bus,
  input  wire logic        board_reset_n_i,
  input  wire logic        req_valid_i,
  input  wire logic [31:0] req_addr_i,
  input  wire logic        req_read_i,
  input  wire logic        dma_chan_i,     // channel serving SCSI
  output logic             req_ready_o,
  output logic             done_o,
  output logic             dma_done_o
);
  import scsi_glue_pkg::*;

  typedef enum {H_IDLE, H_ADDR, H_WAIT, H_END} host_t;
  host_t       st_q;
  logic        dma_q;

  // Region select from the full 32-bit address
  function automatic logic region_of(input logic [31:0] a);
    region_of = (a >= REGION_BASE) && (a <= REGION_LAST);
  endfunction : region_of

  // Memory selects end their own cycles; no board logic answers them
  function automatic logic internal_of(input logic [31:0] a);
    internal_of = (a <= PROG_MEM_LAST) || ((a >= SRAM_BASE) && (a <= SRAM_LAST));
  endfunction : internal_of

  // Pending DMA request on the configured channel wins over CPU requests
  logic dreq;
  assign dreq        = bus.dma_req[dma_chan_i];
  assign req_ready_o = (st_q == H_IDLE) && !dreq;
  assign bus.reset_n = board_reset_n_i;
  assign bus.dma_ack = {dma_q & dma_chan_i, dma_q & !dma_chan_i};

  // Bus cycle: strobes until external acknowledge or an internal memory select, then negate
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q  <= H_IDLE;
      dma_q <= 1'b0;
      bus.addr <= 32'h0;
      bus.rw   <= 1'b1;
      bus.as   <= 1'b0;
      bus.ds   <= 1'b0;
      bus.expansion_region_select <= 1'b0;
      done_o     <= 1'b0;
      dma_done_o <= 1'b0;
    end else begin
      done_o     <= 1'b0;
      dma_done_o <= 1'b0;
      case (st_q)
        H_IDLE: begin
          if (dreq) begin
            // Dual-address: controller side write into the DMA window
            st_q     <= H_ADDR;
            dma_q    <= 1'b1;
            bus.addr <= REGION_BASE | 32'h00f00000;
            bus.rw   <= 1'b0;
          end else if (req_valid_i) begin
            st_q     <= H_ADDR;
            dma_q    <= 1'b0;
            bus.addr <= req_addr_i;
            bus.rw   <= req_read_i;
          end
        end
        H_ADDR: begin
          bus.as <= 1'b1;
          bus.ds <= 1'b1;
          bus.expansion_region_select <= region_of(bus.addr);
          st_q   <= H_WAIT;
        end
        H_WAIT: begin
          if (bus.transfer_size_ack || internal_of(bus.addr)) begin
            st_q <= H_END;
          end
        end
        H_END: begin
          bus.as <= 1'b0;
          bus.ds <= 1'b0;
          bus.expansion_region_select <= 1'b0;
          done_o     <= !dma_q;
          dma_done_o <= dma_q;
          dma_q <= 1'b0;
          st_q  <= H_IDLE;
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end
endmodule : scsi_host_end
`default_nettype wire

// ---- bench/scsi_bus_monitor.sv ----
// Concurrent checks on the processor bus and the glue strobes
`timescale 1ns/1ps
`default_nettype none
module scsi_bus_monitor (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [31:0] addr,
  input wire logic        rw,
  input wire logic        as,
  input wire logic        ds,
  input wire logic        expansion_region_select,
  input wire logic        ack_oe,
  input wire logic        transfer_size_ack,
  input wire logic        reset_n,
  input wire logic        ctrl_cs_o,
  input wire logic        ctrl_rd_o,
  input wire logic        ctrl_wr_o,
  input wire logic        ctrl_dack_o,
  input wire logic        controller_reset_out_o
);
  // ----------------------------------------
  // Decode and properties
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Register or DMA window hit, as the glue sees it
  wire logic sel = as & ds & expansion_region_select & (addr[23:21] == 3'b111);
  a_reg_strobes: assert property ($rose(sel) && !addr[20] |-> ##[1:3]
    ctrl_cs_o && ctrl_rd_o == rw && ctrl_wr_o == !rw) else $error("register strobes wrong");
  a_dma_strobes: assert property ($rose(sel) && addr[20] |-> ##[1:3]
    ctrl_dack_o && !ctrl_cs_o && !ctrl_rd_o) else $error("dma strobes wrong");
  a_ack_delay: assert property ($rose(sel) |-> !transfer_size_ack ##[1:4]
    transfer_size_ack) else $error("acknowledge late or early");
  a_ack_on_strobe: assert property (!as |-> !transfer_size_ack)
    else $error("acknowledge without address strobe");
  a_ack_float: assert property (!expansion_region_select |-> !ack_oe)
    else $error("acknowledge driven outside region");
  a_strobe_release: assert property ($fell(as) |=>
    !(ctrl_cs_o | ctrl_rd_o | ctrl_wr_o | ctrl_dack_o)) else $error("strobes held");
  a_region_qualify: assert property ((as && !expansion_region_select) [*2] |->
    !ctrl_cs_o && !ctrl_dack_o) else $error("strobes without region select");
  a_reset_follow: assert property ($changed(reset_n) |-> ##[1:3]
    controller_reset_out_o == !reset_n) else $error("controller reset wrong");
  cover property ($rose(sel) && addr[20]);
  cover property ($rose(sel) && !addr[20] && rw);
  cover property ($fell(reset_n));
endmodule : scsi_bus_monitor
`default_nettype wire

// ---- bench/testbench.sv ----
// Bench joining the host end to the glue end over the processor bus
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import scsi_glue_pkg::*;
  // ----------------------------------------
  // Signals, ends and checker
  // ----------------------------------------
  logic clk_i = 0, rst_i = 1, brst_n = 0, rv = 0, rr = 0, chan = 0, opt = 0;
  logic dreq = 0, irq = 0, sreq = 0, ready, done, dma_done;
  logic cs, rd, wr, dack, crst, act, dsel, esel, ssel;
  logic [31:0] ra = '0, r;
  logic [2:0]  lvl;
  logic [3:0]  snap = '0;
  logic [4:0]  e, g;
  logic [4:0]  q[$];
  int          seed = 94578, miscompares = 0, num_checks = 0, n;
  cpu_bus_if bus();
  always #10 clk_i = ~clk_i;
  scsi_host_end u_scsi_host_end (.clk_i(clk_i), .rst_i(rst_i), .bus(bus),
    .board_reset_n_i(brst_n), .req_valid_i(rv), .req_addr_i(ra), .req_read_i(rr),
    .dma_chan_i(chan), .req_ready_o(ready), .done_o(done), .dma_done_o(dma_done));
  scsi_glue #(.ACT_CYCLES(8)) u_scsi_glue (.clk_i(clk_i), .rst_i(rst_i), .bus(bus),
    .dma_channel_option_i(opt), .controller_dma_request_i(dreq), .controller_irq_i(irq),
    .scsi_req_i(sreq), .ctrl_cs_o(cs), .ctrl_rd_o(rd), .ctrl_wr_o(wr), .ctrl_dack_o(dack),
    .controller_reset_out_o(crst), .scsi_activity_o(act), .interrupt_level_o(lvl),
    .dram_sel_o(dsel), .exp_card_sel_o(esel), .slot_card_sel_o(ssel));
  scsi_bus_monitor u_monitor (.clk_i(clk_i), .rst_i(rst_i), .addr(bus.addr), .rw(bus.rw),
    .as(bus.as), .ds(bus.ds), .expansion_region_select(bus.expansion_region_select),
    .ack_oe(bus.ack_oe), .transfer_size_ack(bus.transfer_size_ack), .reset_n(bus.reset_n),
    .ctrl_cs_o(cs), .ctrl_rd_o(rd), .ctrl_wr_o(wr), .ctrl_dack_o(dack),
    .controller_reset_out_o(crst));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic tick(int k = 1);
    repeat (k) @(posedge clk_i);
    #1;
  endtask : tick
  task automatic check(string nm, logic [4:0] x, logic [4:0] y);
    num_checks++;
    if (y !== x) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, x, y);
    end
  endtask : check
  // One processor access; only window hits expect a finished transfer
  task automatic cpu(logic [31:0] a, logic rdn);
    n = 0;
    while (ready !== 1'b1 && n < 50) begin tick(); n++; end
    check("host_ready", 5'h1, {4'h0, ready});
    if (a[23:21] == 3'b111) q.push_back({2'b01, rdn, !rdn, 1'b0});
    rv = 1;
    ra = a;
    rr = rdn;
    tick();
    rv = 0;
  endtask : cpu
  // Controller asks for one move, drops its request at acknowledge
  task automatic dma(logic ch);
    n = 0;
    while (ready !== 1'b1 && n < 50) begin tick(); n++; end
    check("host_ready", 5'h1, {4'h0, ready});
    chan = ch; opt = ch; tick();
    q.push_back(5'b10011); dreq = 1; tick(2);
    check("dma_req", {3'b0, ch ? 2'b10 : 2'b01}, {3'b0, bus.dma_req});
    n = 0;
    while (dack !== 1'b1 && n < 50) begin tick(); n++; end
    check("ctrl_dack", 5'h1, {4'h0, dack});
    dreq = 0;
  endtask : dma
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  // ----------------------------------------
  // Result watcher, watchdog and main sequence
  // ----------------------------------------
  // Strobes are captured while acknowledge is up, then matched at done
  // Looked at on the falling edge, where every output has settled
  always @(negedge clk_i) begin
    if (bus.transfer_size_ack === 1'b1) snap = {cs, rd, wr, dack};
    if (done | dma_done) begin
      e = q.pop_front();
      g = {dma_done, snap};
      check("transfer", e, g);
      snap = '0;
    end
  end
  initial begin
    #200000;
    miscompares++;
    final_report();
  end
  initial begin
    tick(16);
    rst_i = 0; brst_n = 1; tick(3);
    check("ctrl_reset", 5'h0, {4'h0, crst});
    brst_n = 0; tick(3);
    check("ctrl_reset", 5'h1, {4'h0, crst});
    brst_n = 1; irq = 1; tick(3);
    check("irq_level", {2'b0, INT_LEVEL_TWO}, {2'b0, lvl});
    irq = 0; tick(3);
    check("irq_level", 5'h0, {2'b0, lvl});
    repeat (6) begin
      r = $random(seed);
      cpu(32'h01e00000 | {27'h0, r[4:0]}, r[8]);
    end
    cpu(32'h01e0001f, 1'b0);
    q.push_back(5'h0);
    cpu(PROG_MEM_LAST, 1'b1);
    q.push_back(5'h0);
    cpu(SRAM_BASE, 1'b0);
    dma(1'b0);
    dma(1'b1);
    n = 0;
    while (q.size() != 0 && n < 200) begin tick(); n++; end
    check("queue_left", 5'h0, 5'(q.size()));
    sreq = 1; tick(); sreq = 0; tick(3);
    check("activity", 5'h1, {4'h0, act});
    tick(3); sreq = 1; tick(); sreq = 0; tick(5);
    check("activity", 5'h1, {4'h0, act});
    tick(12);
    check("activity", 5'h0, {4'h0, act});
    // Unanswered selects: look, then clear the hang with a reset
    for (int i = 0; i < 3; i++) begin
      cpu(i == 0 ? 32'h01000000 : i == 1 ? 32'h01400000 : 32'h00200000, 1'b1);
      tick(6);
      check("card_select", {2'b0, 3'b100 >> i}, {2'b0, dsel, esel, ssel});
      check("ack_float", 5'h0, {4'h0, bus.transfer_size_ack});
      check("ack_enable", {4'h0, i != 2}, {4'h0, bus.ack_oe});
      rst_i = 1; tick(); rst_i = 0; tick(2);
    end
    final_report();
  end
endmodule : testbench
`default_nettype wire
